// >>> verilog/filtered_trace_capture.sv
// Filtered trace capture: trigger compare, post-count, FIFO and bottom-fill buffer.
// Assumes one bus_cycle_in pulse per observed target cycle with latched address and data.
`timescale 1ns/1ps
`include "trace_capture_map.svh"

module trace_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] fill;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	assign in_ready_out = (fill != (PW+1)'(DEPTH));
	assign out_valid_out = (fill != '0);
	assign out_data_out = mem[rd_ptr];
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else if (clk_en_in) begin
			if (flush_in) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				fill <= '0;
			end else begin
				if (push)
					wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
				if (pop)
					rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
				fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (clk_en_in && push)
			mem[wr_ptr] <= in_data_in;
	end
endmodule : trace_fifo

// One sticky control bit: a set pulse and a clear pulse, one of them given priority
module set_clear_flag #(
	parameter bit RESET_VALUE = 1'h0,
	parameter bit SET_WINS = 1'h1
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic set_in,
	input wire logic clear_in,
	output logic flag_out
);
	// Both pulses together resolve by priority so a burst of host commands stays deterministic
	wire set_now = set_in && (SET_WINS || !clear_in);
	wire clear_now = clear_in && (!SET_WINS || !set_in);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			flag_out <= RESET_VALUE;
		else if (clk_en_in) begin
			if (set_now)
				flag_out <= 1'h1;
			else if (clear_now)
				flag_out <= 1'h0;
		end
	end
endmodule : set_clear_flag

// Host setting that loads on one pulse and returns to zero on another
module cleared_register #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] value_in,
	output logic [WIDTH-1:0] value_out
);
	// Clear wins so a mode change never leaves a half-loaded trigger behind
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			value_out <= '0;
		else if (clk_en_in) begin
			if (clear_in)
				value_out <= '0;
			else if (load_in)
				value_out <= value_in;
		end
	end
endmodule : cleared_register

module filtered_trace_capture
	import trace_capture_pkg::*;
#(
	parameter int ADDR_W = `ADDR_WIDTH,
	parameter int DATA_W = `DATA_WIDTH,
	parameter int DEPTH = `TRACE_DEPTH,
	parameter int FIFO_D = `FIFO_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic filter_keep_one_after_in,
	input wire logic filter_keep_two_after_in,
	input wire logic filter_keep_three_after_in,
	input wire logic [ADDR_W-1:0] trig_addr_lo_in,
	input wire logic [ADDR_W-1:0] trig_addr_hi_in,
	input wire logic trig_negate_in,
	input wire logic trig_load_in,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic wide_bus_mode_in,
	input wire logic narrow_bus_mode_in,
	input wire logic high_byte_first_in,
	input wire logic low_byte_first_in,
	input wire logic bus_cycle_in,
	input wire logic [ADDR_W-1:0] bus_addr_in,
	input wire logic [DATA_W-1:0] bus_data_in,
	output logic bus_cycle_ready_out,
	input wire logic [$clog2(DEPTH)-1:0] trace_dump_index_in,
	output logic [ADDR_W+DATA_W-1:0] trace_dump_data_out,
	output logic [$clog2(DEPTH):0] stored_count_out,
	output logic capturing_out,
	output logic capture_done_out,
	output logic wide_active_out,
	output logic high_first_active_out
);
	localparam int CW = $clog2(DEPTH);
	localparam int RW = ADDR_W + DATA_W;
	cap_state_t state;
	cap_state_t next_state;
	logic [`POST_COUNT_WIDTH-1:0] post_sel;
	logic [`POST_COUNT_WIDTH-1:0] post_left;
	logic [ADDR_W-1:0] lo_addr;
	logic [ADDR_W-1:0] hi_addr;
	logic negate;
	logic trig_armed;
	logic wide;
	logic high_first;
	logic [RW-1:0] trace_buf [DEPTH];
	logic [CW:0] count;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [RW-1:0] fifo_out_data;

	wire mode_sel = filter_keep_one_after_in || filter_keep_two_after_in
		|| filter_keep_three_after_in;
	wire [`POST_COUNT_WIDTH-1:0] mode_code = filter_keep_three_after_in ? `POST_THREE :
		filter_keep_two_after_in ? `POST_TWO : `POST_ONE;
	wire above_lo = (bus_addr_in >= lo_addr);
	wire below_hi = (bus_addr_in <= hi_addr);
	wire in_range = above_lo && below_hi;
	wire hit = trig_armed && (in_range ^ negate);
	wire buf_full = (count == (CW+1)'(DEPTH));
	wire watching = (state == cap_watch);
	// A stalled FIFO holds the bus cycle off rather than silently losing a stored record
	wire cycle_taken = watching && bus_cycle_in && fifo_in_ready;
	wire keep = cycle_taken && (hit || (post_left != `POST_NONE));
	wire [DATA_W-1:0] narrow_data = {{(DATA_W-8){1'b0}}, bus_data_in[7:0]};
	wire [DATA_W-1:0] swapped = {bus_data_in[7:0], bus_data_in[DATA_W-1:8]};
	wire [DATA_W-1:0] wide_data = high_first ? bus_data_in : swapped;
	wire [DATA_W-1:0] rec_data = wide ? wide_data : narrow_data;
	wire drain = fifo_out_valid && !buf_full;
	wire [RW-1:0] record = {bus_addr_in, rec_data};
	// A start while already capturing is ignored so queued records are not thrown away
	wire restart = start_in && !watching;

	assign bus_cycle_ready_out = fifo_in_ready;
	assign capturing_out = watching;
	assign capture_done_out = (state == cap_done);
	assign stored_count_out = count;
	assign wide_active_out = wide;
	assign high_first_active_out = high_first;

	trace_fifo #(.WIDTH(RW), .DEPTH(FIFO_D)) u_fifo (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.flush_in(restart),
		.in_valid_in(keep),
		.in_ready_out(fifo_in_ready),
		.in_data_in(record),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(!buf_full),
		.out_data_out(fifo_out_data)
	);

	always_comb begin
		next_state = state;
		case (state)
			cap_idle: begin
				if (start_in && trig_armed)
					next_state = cap_watch;
			end
			cap_watch: begin
				if (stop_in || buf_full || mode_sel)
					next_state = cap_done;
			end
			cap_done: begin
				if (start_in && trig_armed)
					next_state = cap_watch;
			end
			default: next_state = cap_idle;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			state <= cap_idle;
		else if (clk_en_in)
			state <= next_state;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			post_sel <= `POST_ONE;
		else if (clk_en_in && mode_sel)
			post_sel <= mode_code;
	end

	// A new match reloads the count, so overlapping windows merge instead of stacking
	wire post_reload = cycle_taken && hit;
	wire post_step = cycle_taken && !hit && (post_left != `POST_NONE);
	wire post_clear = mode_sel || restart;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			post_left <= `POST_NONE;
		else if (clk_en_in) begin
			if (post_clear)
				post_left <= `POST_NONE;
			else if (post_reload)
				post_left <= post_sel;
			else if (post_step)
				post_left <= post_left - `POST_COUNT_WIDTH'(1);
		end
	end

	// Trigger setup sits in small registers so a mode select wipes it in one cycle
	cleared_register #(.WIDTH(ADDR_W)) u_lo (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.clear_in(mode_sel),
		.load_in(trig_load_in),
		.value_in(trig_addr_lo_in),
		.value_out(lo_addr)
	);

	cleared_register #(.WIDTH(ADDR_W)) u_hi (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.clear_in(mode_sel),
		.load_in(trig_load_in),
		.value_in(trig_addr_hi_in),
		.value_out(hi_addr)
	);

	cleared_register #(.WIDTH(1)) u_negate (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.clear_in(mode_sel),
		.load_in(trig_load_in),
		.value_in(trig_negate_in),
		.value_out(negate)
	);

	set_clear_flag #(.RESET_VALUE(1'h0), .SET_WINS(1'h0)) u_armed (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.set_in(trig_load_in),
		.clear_in(mode_sel),
		.flag_out(trig_armed)
	);

	set_clear_flag #(.RESET_VALUE(1'h1), .SET_WINS(1'h1)) u_wide (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.set_in(wide_bus_mode_in),
		.clear_in(narrow_bus_mode_in),
		.flag_out(wide)
	);

	set_clear_flag #(.RESET_VALUE(1'h1), .SET_WINS(1'h1)) u_high_first (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.set_in(high_byte_first_in),
		.clear_in(low_byte_first_in),
		.flag_out(high_first)
	);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			count <= '0;
		else if (clk_en_in) begin
			if (start_in && state != cap_watch)
				count <= '0;
			else if (drain)
				count <= count + (CW+1)'(1);
		end
	end

	// Bottom is the highest index; each new record pushes older ones toward index 0
	always_ff @(posedge sys_clk_in) begin
		if (clk_en_in && drain) begin
			for (int i = 0; i < DEPTH - 1; i++)
				trace_buf[i] <= trace_buf[i+1];
			trace_buf[DEPTH-1] <= fifo_out_data;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			trace_dump_data_out <= '0;
		else if (clk_en_in)
			trace_dump_data_out <= trace_buf[trace_dump_index_in];
	end
endmodule : filtered_trace_capture

// >>> pkg/trace_capture_map.svh
// Widths, depths, post-count width and post-count codes for the filtered trace capture.
// Assumes inclusion by bare name from the package and design files.
`ifndef TRACE_CAPTURE_MAP_SVH
`define TRACE_CAPTURE_MAP_SVH
`define ADDR_WIDTH 20
`define DATA_WIDTH 16
`define TRACE_DEPTH 256
`define FIFO_DEPTH 4
`define POST_COUNT_WIDTH 2
`define POST_ONE 2'h1
`define POST_TWO 2'h2
`define POST_THREE 2'h3
`define POST_NONE 2'h0
`endif

// >>> pkg/trace_capture_pkg.sv
// Types shared by the filtered trace capture.
// Assumes the map header sits beside it on the include path.
`include "trace_capture_map.svh"
package trace_capture_pkg;
	typedef enum logic [1:0] {
		cap_idle,
		cap_watch,
		cap_done
	} cap_state_t;
endpackage : trace_capture_pkg

// >>> test/target_bus_model.sv
// Model of the observed target bus: one cycle per request.
// Assumes requests come from the bench just after a rising edge.
`timescale 1ns/1ps
module target_bus_model (
	input logic clk_in, go_in, rdy_in,
	input logic [19:0] a_in,
	input logic [15:0] d_in,
	output logic cyc_out = 0,
	output logic [19:0] a_out = 0,
	output logic [15:0] d_out = 0
);
	// Lines toggle when idle so stale values never look valid
	always @(posedge clk_in) if (!(cyc_out && !rdy_in)) begin
		cyc_out <= go_in;
		a_out <= go_in ? a_in : ~a_out;
		d_out <= go_in ? d_in : ~d_out;
	end
endmodule : target_bus_model

// >>> test/trace_capture_monitor.sv
// Port checker for the filtered trace capture.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
module trace_capture_monitor #(parameter int DEPTH = 256) (
	input logic sys_clk_in, rst_n_in, clk_en_in, start_in, stop_in,
	input logic filter_keep_one_after_in, filter_keep_two_after_in,
	input logic filter_keep_three_after_in, capturing_out, capture_done_out,
	input logic [$clog2(DEPTH):0] stored_count_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic sel = filter_keep_one_after_in | filter_keep_two_after_in;
	property p_full;
		clk_en_in && capturing_out && stored_count_out == DEPTH |=> capture_done_out;
	endproperty
	a_full: assert property (p_full) else $error("full, not done");
	property p_step; $changed(stored_count_out) |-> stored_count_out == 0 ||
		stored_count_out == $past(stored_count_out) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("count jump");
	property p_stop; clk_en_in && stop_in && capturing_out |=> capture_done_out; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_sel; clk_en_in && (sel || filter_keep_three_after_in) |=> !capturing_out;
	endproperty
	a_sel: assert property (p_sel) else $error("mode kept capture");
	property p_go; $rose(capturing_out) |-> $past(start_in) && stored_count_out == 0; endproperty
	a_go: assert property (p_go) else $error("bad start");
	property p_hold; !clk_en_in |=> $stable(stored_count_out); endproperty
	a_hold: assert property (p_hold) else $error("moved while frozen");
	property p_excl; capture_done_out |-> !capturing_out; endproperty
	a_excl: assert property (p_excl) else $error("done while capturing");
	property p_end; capturing_out ##1 !capturing_out |-> capture_done_out; endproperty
	a_end: assert property (p_end) else $error("end without done");
	c_full: cover property (capture_done_out && stored_count_out == DEPTH);
	c_stop: cover property (stop_in && capturing_out);
	c_sel: cover property (sel && capture_done_out);
endmodule : trace_capture_monitor

bind filtered_trace_capture trace_capture_monitor #(.DEPTH(DEPTH)) i_mon (.sys_clk_in,
	.rst_n_in, .clk_en_in, .start_in, .stop_in, .filter_keep_one_after_in,
	.filter_keep_two_after_in, .filter_keep_three_after_in, .capturing_out,
	.capture_done_out, .stored_count_out);

// >>> test/tb.sv
// Self-checking bench: random bus traffic against a queue of kept cycles.
// Assumes the capture design and the bus model are compiled first.
`timescale 1ns/1ps
module tb;
	localparam int D = 16;
	logic clk = 0, rst_n = 0, en = 0, go = 0, neg = 0, w = 1, h = 1;
	logic cyc, rdy, cap, done, wa, hf;
	logic [9:0] c = 0;
	logic [19:0] lo = 0, hi = 0, a = 0, ba;
	logic [15:0] d = 0, bd;
	logic [3:0] idx = 0;
	logic [35:0] dq, q[$];
	logic [4:0] cnt;
	logic [31:0] s = 32'h6cf50266;
	int n_fail = 0, samples_checked = 0, post = 0, pn = 1;
	wire logic hit = ((ba >= lo) && (ba <= hi)) ^ neg;
	always #20 clk = ~clk;
	target_bus_model i_bus (.clk_in(clk), .go_in(go), .rdy_in(rdy), .a_in(a), .d_in(d),
		.cyc_out(cyc), .a_out(ba), .d_out(bd));
	filtered_trace_capture #(.DEPTH(D)) i_dut (.sys_clk_in(clk), .rst_n_in(rst_n),
		.clk_en_in(en), .filter_keep_one_after_in(c[0]), .filter_keep_two_after_in(c[1]),
		.filter_keep_three_after_in(c[2]), .trig_addr_lo_in(lo), .trig_addr_hi_in(hi),
		.trig_negate_in(neg), .trig_load_in(c[3]), .start_in(c[4]), .stop_in(c[5]),
		.wide_bus_mode_in(c[6]), .narrow_bus_mode_in(c[7]), .high_byte_first_in(c[8]),
		.low_byte_first_in(c[9]), .bus_cycle_in(cyc), .bus_addr_in(ba), .bus_data_in(bd),
		.bus_cycle_ready_out(rdy), .trace_dump_index_in(idx), .trace_dump_data_out(dq),
		.stored_count_out(cnt), .capturing_out(cap), .capture_done_out(done),
		.wide_active_out(wa), .high_first_active_out(hf));
	function logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : rnd
	always @(posedge clk) if (en && cap && cyc && rdy) begin
		if (hit || post > 0) q.push_back({ba, w ? (h ? bd : {bd[7:0], bd[15:8]}) : {8'h00, bd[7:0]}});
		post = hit ? pn : post > 0 ? post - 1 : 0;
	end
	task give_verdict;
		$display("checked %0d, wrong %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	task chk(logic [35:0] got, logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cmd(int b);
		@(posedge clk);
		c <= 10'h1 << b;
		@(posedge clk);
		c <= 0;
	endtask : cmd
	task automatic run(int m, int n, bit stp);
		int i, k;
		pn = m;
		cmd(m - 1);
		cmd(3);
		q = {};
		post = 0;
		cmd(4);
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			go <= rnd() % 3 != 0;
			a <= 20'(rnd() & 15);
			d <= 16'(rnd());
			en <= rnd() % 8 != 0;
		end
		@(posedge clk);
		go <= 0;
		en <= 1;
		if (stp) cmd(5);
		for (i = 0; i < 99 && done !== 1'b1; i++) @(posedge clk);
		if (done !== 1'b1) begin
			n_fail++;
			give_verdict;
		end
		// FIFO leftovers drain into the buffer after the end
		repeat (8) @(posedge clk);
		k = q.size() < D ? q.size() : D;
		chk(36'(cnt), 36'(k));
		chk(36'({wa, hf}), 36'({w, h}));
		for (i = 0; i < k; i++) begin
			@(posedge clk);
			idx <= 4'(D - 1 - i);
			@(posedge clk);
			@(negedge clk);
			chk(dq, q[k - 1 - i]);
		end
		$display("test with post-count %0d finished", m);
	endtask : run
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		en <= 1;
		lo <= 20'h8;
		hi <= 20'hc;
		run(1, 20, 1);
		cmd(7);
		w = 0;
		neg <= 1;
		lo <= 20'h2;
		hi <= 20'hd;
		run(2, 20, 1);
		cmd(6);
		cmd(9);
		w = 1;
		h = 0;
		neg <= 0;
		lo <= 20'h5;
		hi <= 20'h5;
		run(3, 300, 0);
		give_verdict;
	end
endmodule : tb
